// [verilog/drs_selector.sv]
// dpll reference selector: input routing, monitors, manual and automatic selection, apb registers
// How it works
// - single-ended: each pin drives own line
// - differential: pairs drive lines zero and two
// - loss status readable, optionally on pin
// - loss flagged after programmable missing-edge window
// - frequency window of nominal five milliseconds
// - frequency window of nominal 0.4 seconds
// - manual source is register or pins
// - register manual selects indexed reference line
// - pin code 00..11 selects lines 0..3
// - automatic uses qualification and programmable priorities
// - equal priority: lower index wins
// - register bit chooses revertive or non-revertive
// - revertive: switch only to strictly higher priority
// - non-revertive: keep reference until disqualified
// - no qualified input: free run or holdover
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`default_nettype none
module drs_selector #(
	parameter int unsigned SHORT_CYCLES = drs_pkg::FREQ_SHORT_CYCLES,
	parameter int unsigned LONG_CYCLES  = drs_pkg::FREQ_LONG_CYCLES
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// clock input pins: pair0 true, pair0 comp, pair1 true, pair1 comp
	input  wire logic [3:0]  clk_pin,
	// manual selection pins
	input  wire logic [1:0]  ref_sel_pin,
	// dpll side
	output logic [1:0]       selected_ref,
	output logic             ref_valid,
	output logic             dpll_free_run,
	output logic             dpll_holdover,
	// general purpose pin and interrupt
	output logic             los_gpio,
	output logic             irq
);
	import drs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// declarations
	localparam int unsigned NSYNC = 6;       // four clock pins and two select pins
	logic [NSYNC-1:0]        sync1;          // first stage, read only by sync2
	logic [NSYNC-1:0]        sync2;
	logic [NSYNC-1:0]        sync3;
	logic [NSYNC-1:0]        pin_level;      // agreed level of each pin
	drs_ctrl_type            ctrl;           // control register
	logic [15:0]             ref_priority;   // four priority fields, low value wins
	logic [15:0]             los_window;     // missing-edge window in cycles
	logic [CNT_W-1:0]        freq_expect;    // expected edges per window
	logic [15:0]             freq_tol;       // allowed deviation in edges
	logic [INT_W-1:0]        int_status;     // sticky events
	logic [INT_W-1:0]        int_mask;       // one enables an event onto irq
	logic                    internal_reference_0;
	logic                    internal_reference_1;
	logic                    internal_reference_2;
	logic                    internal_reference_3;
	logic [NUM_REFS-1:0]     ref_line;
	logic [NUM_REFS-1:0]     los;
	logic [NUM_REFS-1:0]     freq_fault;
	logic [NUM_REFS-1:0]     qualified;
	logic [CNT_W-1:0]        freq_count [NUM_REFS];
	drs_state_type           state;
	drs_state_type           next_state;
	logic [1:0]              next_sel;
	logic [1:0]              best_idx;
	logic                    best_found;
	logic [1:0]              manual_target;
	logic [INT_W-1:0]        events;
	logic                    setup_phase;    // access cycle before pready
	logic                    wr_fire;        // write takes effect this edge
	logic [31:0]             read_word;
	logic                    addr_ok;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: a change counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1     <= '0;
			sync2     <= '0;
			sync3     <= '0;
			pin_level <= '0;
		end else begin
			sync1     <= {ref_sel_pin, clk_pin};
			sync2     <= sync1;
			sync3     <= sync2;
			pin_level <= (sync2 & ~(sync2 ^ sync3)) | (pin_level & (sync2 ^ sync3));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// input routing; the complement pin is ignored in differential mode
	always_comb begin
		// true pins always feed lines zero and two
		internal_reference_0 = pin_level[0];
		internal_reference_2 = pin_level[2];
		// complement pins get their own lines only when single-ended
		internal_reference_1 = ctrl.single_ended & pin_level[1];
		internal_reference_3 = ctrl.single_ended & pin_level[3];
	end
	assign ref_line = {internal_reference_3, internal_reference_2,
		internal_reference_1, internal_reference_0};

	////////////////////////////////////////////////////////////////////////////
	// per-line monitors
	for (genvar i = 0; i < NUM_REFS; i++) begin : g_mon
		drs_ref_monitor #(
			.SHORT_CYCLES (SHORT_CYCLES),
			.LONG_CYCLES  (LONG_CYCLES)
		) u_mon (
			.pclk        (pclk),
			.presetn     (presetn),
			.ref_level   (ref_line[i]),
			.long_window (ctrl.long_window),
			.los_window  (los_window),
			.freq_expect (freq_expect),
			.freq_tol    (freq_tol),
			.los         (los[i]),
			.freq_fault  (freq_fault[i]),
			.freq_count  (freq_count[i])
		);
	end

	assign qualified = ~los & ~freq_fault;

	////////////////////////////////////////////////////////////////////////////
	// helpers on the priority register
	function automatic logic [PRIO_W-1:0] prio_of(input logic [15:0] p, input logic [1:0] idx);
		prio_of = p[idx*PRIO_W +: PRIO_W];
	endfunction

	// best qualified line; strict compare keeps the lower index on ties
	always_comb begin
		best_found = 1'b0;
		best_idx   = 2'd0;
		for (int i = 0; i < NUM_REFS; i++) begin
			if (qualified[i] && (!best_found ||
				prio_of(ref_priority, 2'(i)) < prio_of(ref_priority, best_idx))) begin
				best_found = 1'b1;
				best_idx   = 2'(i);
			end
		end
	end

	// manual target from register or pin code
	assign manual_target = ctrl.ref_sel_from_pins ? pin_level[5:4] : ctrl.manual_ref_sel;

	////////////////////////////////////////////////////////////////////////////
	// selection decision
	always_comb begin
		next_sel   = selected_ref;
		next_state = state;
		if (ctrl.auto_mode) begin
			if (state != ST_TRACK || !qualified[selected_ref]) begin
				if (best_found) begin
					next_sel   = best_idx;
					next_state = ST_TRACK;
				end else if (state == ST_TRACK) begin
					next_state = ctrl.loss_goes_free_running ? ST_FREE_RUN : ST_HOLDOVER;
				end
			// revertive only moves to strictly better priority
			end else if (ctrl.revertive_en && best_found &&
				prio_of(ref_priority, best_idx) < prio_of(ref_priority, selected_ref)) begin
				next_sel = best_idx;
			end
			// otherwise the current line is kept
		end else begin
			next_sel = manual_target;
			if (qualified[manual_target]) begin
				next_state = ST_TRACK;
			end else if (state == ST_TRACK) begin
				next_state = ctrl.loss_goes_free_running ? ST_FREE_RUN : ST_HOLDOVER;
			end
		end
	end

	// state and dpll-facing outputs, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state         <= ST_FREE_RUN;
			selected_ref  <= 2'd0;
			ref_valid     <= 1'b0;
			dpll_free_run <= 1'b1;
			dpll_holdover <= 1'b0;
		end else begin
			state        <= next_state;
			selected_ref <= next_sel;
			case (next_state)
				ST_TRACK: begin
					ref_valid     <= 1'b1;
					dpll_free_run <= 1'b0;
					dpll_holdover <= 1'b0;
				end
				ST_HOLDOVER: begin
					ref_valid     <= 1'b0;
					dpll_free_run <= 1'b0;
					dpll_holdover <= 1'b1;
				end
				default: begin
					ref_valid     <= 1'b0;
					dpll_free_run <= 1'b1;
					dpll_holdover <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// loss status steered to the general purpose pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			los_gpio <= 1'b0;
		end else begin
			los_gpio <= ctrl.los_gpio_en & los[ctrl.los_gpio_src];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// apb handshake: one wait state, read data captured with pready
	assign setup_phase = psel & penable & ~pready;
	assign wr_fire     = psel & penable & pready & pwrite;

	// read mux and address decode
	always_comb begin
		read_word = 32'h00000000;
		addr_ok   = 1'b1;
		case (paddr)
			CTRL_OFFSET:       read_word[CTRL_W-1:0] = ctrl;
			PRIORITY_OFFSET:   read_word[15:0] = ref_priority;
			LOS_WINDOW_OFFSET: read_word[15:0] = los_window;
			FREQ_EXP_OFFSET:   read_word[CNT_W-1:0] = freq_expect;
			FREQ_TOL_OFFSET:   read_word[15:0] = freq_tol;
			STATUS_OFFSET: begin
				read_word[STS_LOS_LSB +: NUM_REFS]   = los;
				read_word[STS_FAULT_LSB +: NUM_REFS] = freq_fault;
				read_word[STS_QUAL_LSB +: NUM_REFS]  = qualified;
				read_word[STS_SEL_LSB +: 2]          = selected_ref;
				read_word[STS_VALID_BIT]             = ref_valid;
				read_word[STS_FREE_BIT]              = dpll_free_run;
				read_word[STS_HOLD_BIT]              = dpll_holdover;
			end
			INT_STATUS_OFFSET: read_word[INT_W-1:0] = int_status;
			INT_MASK_OFFSET:   read_word[INT_W-1:0] = int_mask;
			FREQ_CNT_OFFSET:   read_word[CNT_W-1:0] = freq_count[selected_ref];
			default:           addr_ok = 1'b0;
		endcase
	end

	// handshake flops; unmapped addresses answer with pslverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_phase;
			pslverr <= setup_phase & ~addr_ok;
			if (setup_phase && !pwrite) begin
				prdata <= read_word;
			end
		end
	end

	// configuration registers, written at the pready edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl         <= CTRL_RESET;
			ref_priority <= PRIORITY_RESET;
			los_window   <= LOS_WINDOW_RESET;
			freq_expect  <= FREQ_EXP_RESET;
			freq_tol     <= FREQ_TOL_RESET;
			int_mask     <= INT_MASK_RESET;
		end else if (wr_fire) begin
			case (paddr)
				CTRL_OFFSET:       ctrl <= pwdata[CTRL_W-1:0];
				PRIORITY_OFFSET:   ref_priority <= pwdata[15:0];
				LOS_WINDOW_OFFSET: los_window <= pwdata[15:0];
				FREQ_EXP_OFFSET:   freq_expect <= pwdata[CNT_W-1:0];
				FREQ_TOL_OFFSET:   freq_tol <= pwdata[15:0];
				INT_MASK_OFFSET:   int_mask <= pwdata[INT_W-1:0];
				default:           ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// events: new loss per line, reference change, leaving the track state
	logic [NUM_REFS-1:0] los_d;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			los_d <= '1;
		end else begin
			los_d <= los;
		end
	end

	always_comb begin
		events                             = '0;
		events[INT_LOS_LSB +: NUM_REFS]    = los & ~los_d;
		events[INT_SWITCH_BIT] = (next_state == ST_TRACK) &&
			(state != ST_TRACK || next_sel != selected_ref);
		events[INT_NOREF_BIT]  = (state == ST_TRACK) && (next_state != ST_TRACK);
	end

	// sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= '0;
			irq        <= 1'b0;
		end else begin
			if (wr_fire && paddr == INT_STATUS_OFFSET) begin
				int_status <= (int_status & ~pwdata[INT_W-1:0]) | events;
			end else begin
				int_status <= int_status | events;
			end
			irq <= |(int_status & int_mask);
		end
	end

endmodule
`default_nettype wire

// [verilog/drs_pkg.sv]
// package: register map, field layout, reset values and timing of the reference selector
`default_nettype none
package drs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// clock and timing
	localparam int unsigned PCLK_HZ              = 10_000_000;
	// short frequency window, in microseconds
	localparam int unsigned FREQ_SHORT_WINDOW_US = 5000;
	// long frequency window, in milliseconds
	localparam int unsigned FREQ_LONG_WINDOW_MS  = 400;
	localparam int unsigned FREQ_SHORT_CYCLES    = FREQ_SHORT_WINDOW_US * (PCLK_HZ / 1_000_000);
	localparam int unsigned FREQ_LONG_CYCLES     = FREQ_LONG_WINDOW_MS * (PCLK_HZ / 1000);
	localparam int unsigned NUM_REFS             = 4;
	localparam int unsigned WIN_W                = 22;
	localparam int unsigned CNT_W                = 24;
	localparam int unsigned PRIO_W               = 4;

	////////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] CTRL_OFFSET       = 8'h00;
	localparam logic [7:0] PRIORITY_OFFSET   = 8'h04;
	localparam logic [7:0] LOS_WINDOW_OFFSET = 8'h08;
	localparam logic [7:0] FREQ_EXP_OFFSET   = 8'h0c;
	localparam logic [7:0] FREQ_TOL_OFFSET   = 8'h10;
	localparam logic [7:0] STATUS_OFFSET     = 8'h14;
	localparam logic [7:0] INT_STATUS_OFFSET = 8'h18;
	localparam logic [7:0] INT_MASK_OFFSET   = 8'h1c;
	localparam logic [7:0] FREQ_CNT_OFFSET   = 8'h20;

	////////////////////////////////////////////////////////////////////////////
	// control register layout, bit 0 upward from the bottom of the struct
	localparam int unsigned CTRL_W = 11;
	typedef struct packed {
		logic [1:0] los_gpio_src;           // 10:9 which line drives the los pin
		logic       los_gpio_en;            // 8 steer loss status to the pin
		logic       long_window;            // 7 use the long frequency window
		logic       loss_goes_free_running; // 6 no reference: free run, else holdover
		logic       revertive_en;           // 5 revertive automatic selection
		logic [1:0] manual_ref_sel;         // 4:3 manual reference line
		logic       ref_sel_from_pins;      // 2 manual selection taken from pins
		logic       auto_mode;              // 1 automatic selection
		logic       single_ended;           // 0 four single-ended inputs
	} drs_ctrl_type;

	// status register fields
	localparam int unsigned STS_LOS_LSB    = 0;
	localparam int unsigned STS_FAULT_LSB  = 4;
	localparam int unsigned STS_QUAL_LSB   = 8;
	localparam int unsigned STS_SEL_LSB    = 12;
	localparam int unsigned STS_VALID_BIT  = 14;
	localparam int unsigned STS_FREE_BIT   = 15;
	localparam int unsigned STS_HOLD_BIT   = 16;

	// interrupt status and mask fields
	localparam int unsigned INT_W          = 6;
	localparam int unsigned INT_LOS_LSB    = 0;
	localparam int unsigned INT_SWITCH_BIT = 4;
	localparam int unsigned INT_NOREF_BIT  = 5;

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [CTRL_W-1:0] CTRL_RESET       = 11'h022;
	localparam logic [15:0]       PRIORITY_RESET   = 16'h3210;
	localparam logic [15:0]       LOS_WINDOW_RESET = 16'h0008;
	localparam logic [CNT_W-1:0]  FREQ_EXP_RESET   = 24'h000000;
	localparam logic [15:0]       FREQ_TOL_RESET   = 16'hffff;
	localparam logic [INT_W-1:0]  INT_MASK_RESET   = 6'h00;

	////////////////////////////////////////////////////////////////////////////
	// dpll reference state, gray coded along free run, track, holdover
	typedef enum logic [1:0] {
		ST_FREE_RUN = 2'b00,
		ST_TRACK    = 2'b01,
		ST_HOLDOVER = 2'b11
	} drs_state_type;

endpackage
`default_nettype wire

// [verilog/drs_ref_monitor.sv]
// one reference line monitor: missing-edge detector and windowed frequency counter
`default_nettype none
module drs_ref_monitor #(
	parameter int unsigned SHORT_CYCLES = drs_pkg::FREQ_SHORT_CYCLES,
	parameter int unsigned LONG_CYCLES  = drs_pkg::FREQ_LONG_CYCLES
) (
	// clock and reset
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// reference line, already synchronised
	input  wire logic                      ref_level,
	// configuration
	input  wire logic                      long_window,
	input  wire logic [15:0]               los_window,
	input  wire logic [drs_pkg::CNT_W-1:0] freq_expect,
	input  wire logic [15:0]               freq_tol,
	// results
	output logic                           los,
	output logic                           freq_fault,
	output logic [drs_pkg::CNT_W-1:0]      freq_count
);
	import drs_pkg::*;

	logic             ref_d;    // previous level for edge detect
	logic [15:0]      gap;      // cycles since the last rising edge
	logic [WIN_W-1:0] win_cnt;  // position in the frequency window
	logic [CNT_W-1:0] edge_cnt; // edges seen in this window
	logic [WIN_W-1:0] win_last; // last cycle of the chosen window
	logic [CNT_W-1:0] final_cnt;
	logic             rise;

	assign rise      = ref_level & ~ref_d;
	assign win_last  = long_window ? WIN_W'(LONG_CYCLES - 1) : WIN_W'(SHORT_CYCLES - 1);
	assign final_cnt = edge_cnt + CNT_W'(rise);

	// absolute difference of two counts
	function automatic logic [CNT_W-1:0] abs_diff(input logic [CNT_W-1:0] a,
		input logic [CNT_W-1:0] b);
		abs_diff = (a > b) ? a - b : b - a;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// missing edge window
	// gap saturates so a dead line stays flagged forever
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_d <= 1'b0;
			gap   <= 16'h0000;
			los   <= 1'b1;
		end else begin
			ref_d <= ref_level;
			if (rise) begin
				gap <= 16'h0000;
				los <= 1'b0;
			end else begin
				if (gap != 16'hffff) begin
					gap <= gap + 16'h0001;
				end
				los <= (gap >= los_window);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// frequency window
	// a switch to the short window mid-count ends the window early, the next one is clean
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_cnt    <= '0;
			edge_cnt   <= '0;
			freq_count <= '0;
			freq_fault <= 1'b0;
		end else if (win_cnt >= win_last) begin
			win_cnt    <= '0;
			edge_cnt   <= '0;
			freq_count <= final_cnt;
			freq_fault <= (abs_diff(final_cnt, freq_expect) > CNT_W'(freq_tol));
		end else begin
			win_cnt  <= win_cnt + WIN_W'(1);
			edge_cnt <= final_cnt;
		end
	end

endmodule
`default_nettype wire

// [sim/drs_ref_source.sv]
// partner model: external reference clock sources and selection pin driver
`default_nettype none
module drs_ref_source #(
	parameter int HALF_NS = 400 // half period of every source
) (
	// control from the bench
	input  wire logic [3:0] run,
	input  wire logic [1:0] code,
	// pins toward the device
	output wire logic [3:0] clk_pin,
	output logic [1:0]      ref_sel_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	////////////////////////////////////////////////////////////////////////////
	// one free oscillator per pin; a stopped source sits low so edges vanish
	for (genvar i = 0; i < 4; i++) begin : g_src
		logic lvl; // current pin level
		initial begin
			lvl = 1'b0;
			// staggered phases so no two pins edge together
			#(i * 37 + 11);
			forever begin
				#HALF_NS;
				lvl = run[i] ? ~lvl : 1'b0;
			end
		end
		assign clk_pin[i] = lvl;
	end
	assign ref_sel_pin = code;
endmodule
`default_nettype wire

// [sim/drs_selector_chk.sv]
// checker: apb timing and dpll state relations at the selector ports
`default_nettype none
module drs_selector_chk (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic [7:0]  paddr,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pwrite,
	input wire logic        pready,
	input wire logic        pslverr,
	// dpll side
	input wire logic        ref_valid,
	input wire logic        dpll_free_run,
	input wire logic        dpll_holdover
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////////////////////////////////////////////////////////////////
	// apb answer only after an access phase, one cycle wide
	a_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
		else $error("pready without access phase");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held two cycles");
	a_err_ready: assert property (pslverr |-> pready && psel)
		else $error("pslverr outside answer");
	a_err_unmapped: assert property (pslverr |-> (paddr > 8'h20 || paddr[1:0] != 2'b00))
		else $error("pslverr on mapped address");
	a_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("error read returned data");
	////////////////////////////////////////////////////////////////////////////
	// exactly one dpll state at a time
	a_state_single: assert property ($onehot({ref_valid, dpll_free_run, dpll_holdover}))
		else $error("dpll state not single");
	a_hold_entry: assert property ($rose(dpll_holdover) |-> $past(ref_valid))
		else $error("holdover not from tracking");
	a_free_entry: assert property ($rose(dpll_free_run) |-> $past(ref_valid))
		else $error("free run entered while not tracking");
endmodule
bind drs_selector drs_selector_chk i_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
	.psel(psel), .penable(penable), .prdata(prdata), .pwrite(pwrite), .pready(pready),
	.pslverr(pslverr), .ref_valid(ref_valid), .dpll_free_run(dpll_free_run),
	.dpll_holdover(dpll_holdover));
`default_nettype wire

// [sim/drs_selector_tb.sv]
// testbench: apb driven sequences over the reference selector
`default_nettype none
module drs_selector_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import drs_pkg::*;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, ref_valid, dpll_free_run, dpll_holdover, los_gpio, irq;
	logic [1:0]  selected_ref, ref_sel_pin, code = 2'h0;
	logic [3:0]  clk_pin, run = 4'h0;
	int          failures = 0, tests_run = 0, cyc = 0;
	always #50 pclk = ~pclk;
	drs_selector #(.SHORT_CYCLES(64), .LONG_CYCLES(256)) i_dut (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.clk_pin(clk_pin), .ref_sel_pin(ref_sel_pin), .selected_ref(selected_ref),
		.ref_valid(ref_valid), .dpll_free_run(dpll_free_run), .dpll_holdover(dpll_holdover),
		.los_gpio(los_gpio), .irq(irq));
	drs_ref_source i_src (.run(run), .code(code), .clk_pin(clk_pin), .ref_sel_pin(ref_sel_pin));
	////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// hang guard, far above the planned run
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			failures++;
			print_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no cycle count assumed; a stuck slave is caught by the hang guard
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		chk("slverr", {31'h0, pslverr}, {31'h0, a > 8'h20});
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// covers loss window plus pin synchroniser delay
	task automatic settle();
		wait_cyc(40);
	endtask
	task automatic sel_is(input logic [1:0] s);
		chk("selected", {29'h0, ref_valid, selected_ref}, {29'h0, 1'b1, s});
	endtask
	////////////////////////////////////////////////////////////////////////////
	initial begin
		wait_cyc(2);
		presetn <= 1'b1;
		// reset values and an unmapped place
		apb(0, CTRL_OFFSET, 0); chk("ctrl", rd, 32'(CTRL_RESET));
		apb(0, PRIORITY_OFFSET, 0); chk("prio", rd, 32'(PRIORITY_RESET));
		apb(0, FREQ_TOL_OFFSET, 0); chk("tol", rd, 32'(FREQ_TOL_RESET));
		apb(0, 8'h40, 0); chk("unmapped", rd, 32'h0);
		$display("test registers done");
		// routing and automatic choice
		run = 4'hf;
		apb(1, LOS_WINDOW_OFFSET, 32'h10);
		settle();
		apb(0, STATUS_OFFSET, 0); chk("qual diff", 32'(rd[11:8]), 32'h5);
		sel_is(2'd0);
		apb(1, CTRL_OFFSET, 32'h023); settle();
		apb(0, STATUS_OFFSET, 0); chk("qual se", 32'(rd[11:8]), 32'hf);
		apb(1, PRIORITY_OFFSET, 32'h1111); wait_cyc(3); sel_is(2'd0);
		run = 4'he; settle(); sel_is(2'd1);
		apb(0, STATUS_OFFSET, 0); chk("los bits", 32'(rd[3:0]), 32'h1);
		apb(1, PRIORITY_OFFSET, 32'h0123); wait_cyc(3); sel_is(2'd3);
		apb(1, CTRL_OFFSET, 32'h003); run = 4'h6; settle(); sel_is(2'd2);
		run = 4'he; settle(); sel_is(2'd2);
		apb(1, CTRL_OFFSET, 32'h023); wait_cyc(3); sel_is(2'd3);
		$display("test automatic done");
		// switch interrupt: masked, unmasked, cleared
		chk("irq masked", {31'h0, irq}, 32'h0);
		apb(1, INT_MASK_OFFSET, 32'h10); wait_cyc(2); chk("irq on", {31'h0, irq}, 32'h1);
		apb(1, INT_STATUS_OFFSET, 32'h10); wait_cyc(2); chk("irq off", {31'h0, irq}, 32'h0);
		$display("test interrupt done");
		// all lost: holdover, then free run
		apb(1, CTRL_OFFSET, 32'h523); run = 4'h0; settle();
		chk("hold", {30'h0, dpll_holdover, ref_valid}, 32'h2);
		chk("gpio", {31'h0, los_gpio}, 32'h1);
		run = 4'hf; settle(); sel_is(2'd3);
		apb(1, CTRL_OFFSET, 32'h563); run = 4'h0; settle();
		chk("free", {30'h0, dpll_free_run, ref_valid}, 32'h2);
		$display("test loss done");
		// frequency counts in short and long window, then a forced fault
		run = 4'hf; apb(1, CTRL_OFFSET, 32'h023); wait_cyc(140);
		apb(0, FREQ_CNT_OFFSET, 0); chk("short cnt", {31'h0, rd >= 7 && rd <= 9}, 32'h1);
		apb(1, CTRL_OFFSET, 32'h0a3); wait_cyc(600);
		apb(0, FREQ_CNT_OFFSET, 0); chk("long cnt", {31'h0, rd >= 31 && rd <= 33}, 32'h1);
		apb(1, CTRL_OFFSET, 32'h023); apb(1, FREQ_EXP_OFFSET, 32'd100);
		apb(1, FREQ_TOL_OFFSET, 32'h1); wait_cyc(140);
		chk("fault valid", {31'h0, ref_valid}, 32'h0);
		apb(1, FREQ_TOL_OFFSET, 32'hffff); wait_cyc(140);
		$display("test frequency done");
		// manual from register, then from pins
		for (int i = 0; i < 4; i++) begin
			apb(1, CTRL_OFFSET, 32'h001 | (32'(i) << 3)); wait_cyc(3); sel_is(2'(i));
		end
		for (int i = 0; i < 4; i++) begin
			code <= 2'(i); apb(1, CTRL_OFFSET, 32'h005); wait_cyc(8); sel_is(2'(i));
		end
		$display("test manual done");
		print_verdict();
	end
endmodule
`default_nettype wire
